// ===== logic/aij_regs.svh
// Constants for the converter injection result path
`ifndef AIJ_REGS_SVH
`define AIJ_REGS_SVH
`define AIJ_DATA_W 10
`define AIJ_CHAN_W 5
`define AIJ_CONV_NS 3000
`define AIJ_CLK_NS 50
`define AIJ_CONV_CYC ((`AIJ_CONV_NS + `AIJ_CLK_NS - 1) / `AIJ_CLK_NS)
`define AIJ_CNT_W 8
`define AIJ_ZERO_DATA 10'h000
`define AIJ_ZERO_CHAN 5'h00
`endif

// ===== logic/aij_pkg.sv
// Types shared by both ends of the injection result path
`default_nettype none
`include "aij_regs.svh"
package aij_pkg;
  typedef logic [`AIJ_DATA_W-1:0] aij_data_t;
  typedef logic [`AIJ_CHAN_W-1:0] aij_chan_t;
  typedef enum logic [1:0] {AIJ_STD, AIJ_INJ} aij_kind_t;
endpackage : aij_pkg
`default_nettype wire

// ===== logic/aij_if.sv
// Link between the converter end and the result reader end
`timescale 1ns/1ps
`default_nettype none
interface aij_if;
  import aij_pkg::*;
  // Converter to reader
  aij_data_t inj_result;
  aij_data_t std_result;
  logic injection_done_irq;
  logic std_done;
  // Reader to converter
  logic inj_read;
  logic std_read;
  modport dev (output inj_result, output std_result, output injection_done_irq,
    output std_done, input inj_read, input std_read);
  modport rdr (input inj_result, input std_result, input injection_done_irq,
    input std_done, output inj_read, output std_read);
endinterface : aij_if
`default_nettype wire

// ===== logic/aij_reader.sv
// Reader end: event transfer channel fetching injected results
`timescale 1ns/1ps
`default_nettype none
`include "aij_regs.svh"
module aij_reader
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Link
  aij_if.rdr lnk,
  // User side
  input wire logic xfer_enable,
  output logic out_valid,
  output aij_pkg::aij_data_t out_data,
  output logic out_std_valid,
  output aij_pkg::aij_data_t out_std_data
);
  import aij_pkg::*;

  // ------------------------------------------------------------
  // Read issue
  // ------------------------------------------------------------
  logic pend_q;
  logic second_q;
  logic rd_fire;
  logic rd_second;
  // Each irq is serviced once enabled; a second read follows every fetch
  assign rd_fire = pend_q && xfer_enable;
  assign rd_second = second_q;
  assign lnk.inj_read = (rd_fire || rd_second) && clk_en;
  assign lnk.std_read = lnk.std_done && clk_en;

  // Pending request is kept while servicing is blocked; further irqs merge into it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_q <= 1'b0;
      second_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pend_q <= lnk.injection_done_irq || (pend_q && !rd_fire);
      second_q <= rd_fire;
    end
  end

  // ------------------------------------------------------------
  // Captured data
  // ------------------------------------------------------------
  // The double read returns the same word unless the first read releases a held value; only the first is reported
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_data <= `AIJ_ZERO_DATA;
      out_std_valid <= 1'b0;
      out_std_data <= `AIJ_ZERO_DATA;
    end
    else if (clk_en)
    begin
      out_valid <= rd_fire;
      out_std_valid <= lnk.std_done;
      if (rd_fire)
        out_data <= lnk.inj_result;
      if (lnk.std_done)
        out_std_data <= lnk.std_result;
    end
  end
endmodule : aij_reader
`default_nettype wire

// ===== logic/aij_converter.sv
// Converter end: injection control, holding register and result registers
// Functional notes
// - Injection works only in wait-for-read mode
// - Injection converts one channel, scan mode untouched
// - Finished injection loads result, raises done flag
// - Full holding register suspends next conversion
// - New injection result waits until previous read
// - Read moves held value, raises fresh irq
// - Hardware trigger from channel thirty one accepted
// - Reader may fetch via event transfer channel
// - Toggling wait mode off/on releases stall
// - Reader should read injected result twice
// - Reader must not block two pending injections
`timescale 1ns/1ps
`default_nettype none
`include "aij_regs.svh"
module aij_converter
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Mode control
  input wire logic wait_read_mode,
  input wire logic scan_enable,
  input wire aij_pkg::aij_chan_t scan_chan,
  input wire aij_pkg::aij_chan_t inj_chan,
  // Injection requests
  input wire logic inj_sw_req,
  input wire logic capture_compare_channel_thirty_one,
  // Analog front end model input
  input wire aij_pkg::aij_data_t sample_in,
  // Status
  output logic busy,
  output logic injection_done_flag,
  output aij_pkg::aij_chan_t conv_chan,
  // Link
  aij_if.dev lnk
);
  import aij_pkg::*;

  // ------------------------------------------------------------
  // Trigger synchroniser
  // ------------------------------------------------------------
  logic [2:0] trig_q;
  logic trig_lvl_q;
  logic trig_rise;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trig_q <= 3'h0;
      trig_lvl_q <= 1'b0;
    end
    else if (clk_en)
    begin
      trig_q <= {trig_q[1:0], capture_compare_channel_thirty_one};
      if (trig_q[1] == trig_q[2])
        trig_lvl_q <= trig_q[2];
    end
  end
  // A rising change counts once stages two and three agree
  assign trig_rise = (trig_q[1] == trig_q[2]) && trig_q[2] && !trig_lvl_q;

  // ------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------
  logic inj_pend_q;
  logic inj_req;
  logic mode_q;
  logic mode_rise;
  // Software and channel thirty one both request an injection
  assign inj_req = (inj_sw_req || trig_rise) && wait_read_mode;
  assign mode_rise = wait_read_mode && !mode_q;

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_CONV, S_DONE} aij_st_t;
  aij_st_t st_q;
  aij_st_t st_d;
  aij_kind_t kind_q;
  logic [`AIJ_CNT_W-1:0] cnt_q;
  logic cnt_end;
  logic hold_full_q;
  aij_kind_t hold_kind_q;
  aij_data_t hold_q;
  aij_data_t inj_res_q;
  aij_data_t std_res_q;
  logic inj_unread_q;
  logic std_unread_q;
  logic start_ok;
  logic do_inj;
  logic do_std;
  logic fin;
  logic fin_inj;
  logic fin_std;
  logic inj_slot_free;
  logic std_slot_free;
  logic to_hold;
  logic rd_inj;
  logic rd_std;
  logic release_hold;
  logic irq_d;

  assign cnt_end = (cnt_q == `AIJ_CNT_W'(`AIJ_CONV_CYC - 1));
  // Nothing starts while the holding register is occupied
  assign start_ok = (st_q == S_IDLE) && !hold_full_q;
  // Injection outranks scan but does not disturb scan settings
  assign do_inj = start_ok && (inj_pend_q || inj_req);
  assign do_std = start_ok && !do_inj && scan_enable;
  assign fin = (st_q == S_DONE);
  assign fin_inj = fin && (kind_q == AIJ_INJ);
  assign fin_std = fin && (kind_q == AIJ_STD);
  assign rd_inj = lnk.inj_read && clk_en;
  assign rd_std = lnk.std_read && clk_en;
  assign inj_slot_free = !inj_unread_q || rd_inj || !wait_read_mode;
  assign std_slot_free = !std_unread_q || rd_std || !wait_read_mode;
  // In wait-for-read mode, a result whose register is still unread goes to the holding register
  assign to_hold = (fin_inj && !inj_slot_free) || (fin_std && !std_slot_free);
  // A read of the right register or a wait-mode restart empties the hold
  assign release_hold = hold_full_q && (mode_rise
    || ((hold_kind_q == AIJ_INJ) && rd_inj) || ((hold_kind_q == AIJ_STD) && rd_std));
  assign irq_d = (fin_inj && !to_hold) || (release_hold && hold_kind_q == AIJ_INJ);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (do_inj || do_std) st_d = S_CONV;
      S_CONV: if (cnt_end) st_d = S_DONE;
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  // Sequencer state and per-conversion bookkeeping
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= S_IDLE;
      kind_q <= AIJ_STD;
      cnt_q <= '0;
      conv_chan <= `AIJ_ZERO_CHAN;
      inj_pend_q <= 1'b0;
      mode_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      mode_q <= wait_read_mode;
      cnt_q <= (st_q == S_CONV) ? cnt_q + 1'b1 : '0;
      // A request seen while busy waits here; a newer one merges into it
      inj_pend_q <= (inj_pend_q || inj_req) && !do_inj;
      if (do_inj || do_std)
      begin
        kind_q <= do_inj ? AIJ_INJ : AIJ_STD;
        conv_chan <= do_inj ? inj_chan : scan_chan;
      end
    end
  end

  // ------------------------------------------------------------
  // Result and holding registers
  // ------------------------------------------------------------
  // Unread flags: the new result wins over a read in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hold_full_q <= 1'b0;
      hold_kind_q <= AIJ_STD;
      hold_q <= `AIJ_ZERO_DATA;
      inj_res_q <= `AIJ_ZERO_DATA;
      std_res_q <= `AIJ_ZERO_DATA;
      inj_unread_q <= 1'b0;
      std_unread_q <= 1'b0;
      injection_done_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (to_hold)
      begin
        hold_full_q <= 1'b1;
        hold_kind_q <= kind_q;
        hold_q <= sample_in;
      end
      else if (release_hold)
        hold_full_q <= 1'b0;
      if (fin_inj && !to_hold)
        inj_res_q <= sample_in;
      else if (release_hold && hold_kind_q == AIJ_INJ)
        inj_res_q <= hold_q;
      if (fin_std && !to_hold)
        std_res_q <= sample_in;
      else if (release_hold && hold_kind_q == AIJ_STD)
        std_res_q <= hold_q;
      inj_unread_q <= irq_d || (inj_unread_q && !rd_inj);
      std_unread_q <= (fin_std && !to_hold) || (release_hold && hold_kind_q == AIJ_STD)
        || (std_unread_q && !rd_std);
      injection_done_flag <= irq_d || (injection_done_flag && !rd_inj);
    end
  end

  // ------------------------------------------------------------
  // Link outputs
  // ------------------------------------------------------------
  logic irq_q;
  logic std_done_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_q <= 1'b0;
      std_done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_q <= irq_d;
      std_done_q <= (fin_std && !to_hold) || (release_hold && hold_kind_q == AIJ_STD);
    end
  end
  assign lnk.injection_done_irq = irq_q && clk_en;
  assign lnk.std_done = std_done_q && clk_en;
  assign lnk.inj_result = inj_res_q;
  assign lnk.std_result = std_res_q;
  assign busy = (st_q != S_IDLE) || hold_full_q;
endmodule : aij_converter
`default_nettype wire

// ===== dv/aij_props.sv
// Concurrent checks on the link between the converter and reader ends
`timescale 1ns/1ps
`default_nettype none
module aij_props
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link signals
  input wire aij_pkg::aij_data_t inj_result,
  input wire aij_pkg::aij_data_t std_result,
  input wire logic injection_done_irq,
  input wire logic std_done,
  input wire logic inj_read,
  input wire logic std_read
);
  import aij_pkg::*;
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------
  // Assertions
  // ------------------------------
  property p_irq_pulse;
    injection_done_irq |=> !injection_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
  property p_std_pulse;
    std_done |=> !std_done;
  endproperty
  a_std_pulse: assert property (p_std_pulse) else $error("std_done too wide");
  // A new injected value is always announced, including after a held move
  property p_inj_chg;
    $changed(inj_result) |-> ##[0:2] injection_done_irq;
  endproperty
  a_inj_chg: assert property (p_inj_chg) else $error("silent injected update");
  property p_std_chg;
    $changed(std_result) |-> ##[0:2] std_done;
  endproperty
  a_std_chg: assert property (p_std_chg) else $error("silent standard update");
  // Only one holding register, so two results never land together
  property p_one_res;
    $changed(inj_result) |-> $stable(std_result);
  endproperty
  a_one_res: assert property (p_one_res) else $error("both results moved");
  property p_excl;
    injection_done_irq |-> !std_done;
  endproperty
  a_excl: assert property (p_excl) else $error("two completions at once");
  property p_irq_hold;
    injection_done_irq |=> $stable(inj_result);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("result overwritten");
  property p_rst_clear;
    $rose(rstn) |-> !injection_done_irq && !std_done && inj_result == 10'h000;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("link busy after reset");
  // Main scenarios reached
  c_irq: cover property (injection_done_irq);
  c_dbl: cover property (inj_read ##1 inj_read);
  c_std: cover property (std_done ##[0:3] std_read);
endmodule : aij_props
`default_nettype wire

// ===== dv/adc_injection_result_buffer_tb.sv
// Testbench joining the converter and reader ends of the injection path
`timescale 1ns/1ps
`default_nettype none
module adc_injection_result_buffer_tb;
  import aij_pkg::*;
  logic clk, rstn, cen, wmode, scan, sw, hw, xen, busy, flag, ov, osv;
  aij_chan_t schan, ichan, cch;
  aij_data_t smp, od, osd, want;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_ov = 0;
  aij_if lnk ();
  aij_converter aij_converter_inst (.clk(clk), .rstn(rstn), .clk_en(cen),
    .wait_read_mode(wmode), .scan_enable(scan), .scan_chan(schan), .inj_chan(ichan),
    .inj_sw_req(sw), .capture_compare_channel_thirty_one(hw), .sample_in(smp),
    .busy(busy), .injection_done_flag(flag), .conv_chan(cch), .lnk(lnk.dev));
  aij_reader aij_reader_inst (.clk(clk), .rstn(rstn), .clk_en(cen), .lnk(lnk.rdr),
    .xfer_enable(xen), .out_valid(ov), .out_data(od), .out_std_valid(osv),
    .out_std_data(osd));
  aij_props aij_props_inst (.clk(clk), .rstn(rstn), .inj_result(lnk.inj_result),
    .std_result(lnk.std_result), .injection_done_irq(lnk.injection_done_irq),
    .std_done(lnk.std_done), .inj_read(lnk.inj_read), .std_read(lnk.std_read));
  // Clock, and a cycle ceiling so a stalled converter cannot hang the run
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ov === 1'b1)
      n_ov <= n_ov + 1;
    if (cyc == 8000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task automatic chk_d(input string n, input aij_data_t e, input aij_data_t g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_d
  task automatic chk_b(input string n, input logic e, input logic g);
    chk_d(n, {9'h000, e}, {9'h000, g});
  endtask : chk_b
  // Bounded wait: 0 flag set, 1 standard fetch, 2 injected channel, 3 wanted fetch
  task automatic wait_on(input int w);
    int i;
    i = 0;
    while (i < 400 && !((w == 0 && flag === 1'b1) || (w == 1 && osv === 1'b1) ||
      (w == 2 && cch === ichan) || (w == 3 && ov === 1'b1 && od === want)))
    begin
      step(1);
      i++;
    end
  endtask : wait_on
  task automatic inject(input aij_data_t v);
    smp = v;
    sw = 1'b1;
    step(1);
    sw = 1'b0;
  endtask : inject
  task automatic get_inj(input aij_data_t v);
    want = v;
    wait_on(3);
    chk_d("inj_data", v, od);
    step(4);
  endtask : get_inj
  // Stall with a value held, then release by servicing or by mode toggle
  task automatic t_block(input logic toggle);
    xen = 1'b0;
    inject(10'h1A5);
    wait_on(0);
    inject(10'h25A);
    step(150);
    chk_b("flag_held", 1'b1, flag);
    chk_d("inj_kept", 10'h1A5, lnk.inj_result);
    if (toggle)
    begin
      wmode = 1'b0;
      step(2);
      wmode = 1'b1;
      step(2);
      chk_d("inj_release", 10'h25A, lnk.inj_result);
    end
    xen = 1'b1;
    get_inj(10'h25A);
    inject(10'h3C3);
    get_inj(10'h3C3);
  endtask : t_block
  task automatic test_done;
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    int k;
    rstn = 1'b0;
    cen = 1'b1;
    {wmode, scan, sw, hw, xen} = 5'h19;
    schan = 5'h03;
    ichan = 5'h11;
    smp = 10'h000;
    want = 10'h000;
    step(5);
    rstn = 1'b1;
    step(2);
    inject(10'h2A5);
    get_inj(10'h2A5);
    chk_b("flag_clear", 1'b0, flag);
    smp = 10'h15A;
    hw = 1'b1;
    step(8);
    hw = 1'b0;
    get_inj(10'h15A);
    wmode = 1'b0;
    k = n_ov;
    inject(10'h0C3);
    step(100);
    chk_b("no_fetch", 1'b1, n_ov == k);
    wmode = 1'b1;
    t_block(1'b0);
    t_block(1'b1);
    smp = 10'h0F0;
    scan = 1'b1;
    // A fetch already under way still carries the previous sample
    step(2);
    wait_on(1);
    chk_d("std_data", 10'h0F0, osd);
    inject(10'h0F0);
    wait_on(2);
    chk_b("inj_chan", 1'b1, cch === ichan);
    get_inj(10'h0F0);
    wait_on(1);
    chk_b("scan_runs", 1'b1, osv);
    scan = 1'b0;
    step(150);
    // Clock enable low freezes a running conversion and masks the link
    k = n_ov;
    inject(10'h2C2);
    step(20);
    cen = 1'b0;
    step(100);
    chk_b("frozen_busy", 1'b1, busy);
    chk_b("frozen_fetch", 1'b1, n_ov == k);
    cen = 1'b1;
    get_inj(10'h2C2);
    test_done();
  end
endmodule : adc_injection_result_buffer_tb
`default_nettype wire
